// ===== rtl/mac_table_access_control.sv
/*
  Software access and maintenance controller for the hashed MAC table:
  status and overflow count, entry read/write/clear/search, table purges,
  port stripping and fetch of the last unknown source address.
  Assumes a held-request register port (request held until ready) and a
  lookup engine that pulses src_miss and table_overflow in sys_clk.
*/
// Functional notes
// - Any source lookup miss sets the new-source flag; it stays set.
// - Flag clears on write-one to its bit, or on fetch command.
// - Count table overflows, forced evictions, in a 14-bit field.
// - Status write with bit 16 set zeroes the overflow counter, or sets it to one if an overflow pulses in the same cycle.
// - Read-only 16-bit field shows next index aging will inspect.
// - Busy and command bit stay high during execution, cleared together.
// - Port strip scans all entries, dynamic valid only, using low NUM_PORTS bits of address field as port set.
// - Overlapping entries lose given ports; empty port mask invalidates entry.
// - Clear alone zeroes indexed entry and both data registers.
// - Clear with search: search first, delete on hit, ignore on miss.
// - Search MAC in data registers; hit loads high bits and index.
// - Miss clears valid, returns first empty slot, else last slot if full: hash in 12:3, offset 2:0.
// - Wait bit stalls the bus write until the command completes.
// - Single read copies indexed entry into the data registers.
// - Low data reads return last captured data, not live table.
// - Fetch copies captured unknown source and its arrival port mask.
// - Fetch sets valid only if new address captured since last fetch.
// - One unknown source held; always captured; newer overwrites older.
// - Purge-static zeroes every valid static entry over full scan.
// - Purge-learned zeroes every valid dynamic entry over full scan.
// - Index selects one 64-bit entry; low word bytes one to four.
// - High register holds entry bits 57:32; bit 16 is valid.
`timescale 1ns/10ps
`default_nettype none

module mac_table_access_control
  import mac_table_pkg::*;
#(
  parameter int TABLE_DEPTH = 8192,
  parameter int NUM_PORTS = 5
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ready,
  input wire logic src_miss,
  input wire logic [MAC_W-1:0] src_miss_mac,
  input wire logic [$clog2(NUM_PORTS)-1:0] src_miss_port,
  input wire logic table_overflow,
  input wire logic [STAT_AGE_W-1:0] age_index
);

  localparam int IDX_W = $clog2(TABLE_DEPTH);
  localparam int HASH_W = IDX_W - BUCKET_W;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(TABLE_DEPTH - 1);
  localparam logic [BUCKET_W-1:0] LAST_SLOT = '1;

  // Elaboration-time refusal of sizes the logic cannot serve
  if (TABLE_DEPTH > TABLE_DEPTH_MAX || TABLE_DEPTH != (1 << IDX_W) || HASH_W < 1)
  begin
    $error("TABLE_DEPTH must be a power of two from 16 to 8192");
  end
  if (NUM_PORTS < 2 || NUM_PORTS > ENT_PORT_MAX)
  begin
    $error("NUM_PORTS must be from 2 to 8");
  end

  // ==========================================================
  // Declarations
  engine_state_t state_q;
  logic busy_q;
  logic [CTRL_STRIP_BIT:CTRL_PLEARN_BIT] cmd_q;
  logic [CTRL_ADDR_W-1:0] addr_field_q;
  logic [IDX_W-1:0] cur_idx_q;
  logic free_found_q;
  logic [IDX_W-1:0] free_idx_q;
  logic [31:0] data_low_q;
  logic [DATA_HIGH_W-1:0] data_high_q;
  logic event_q;
  logic [STAT_OVF_W-1:0] ovf_q;
  logic [MAC_W-1:0] cap_mac_q;
  logic [$clog2(NUM_PORTS)-1:0] cap_port_q;
  logic cap_new_q;
  logic wait_q;
  logic ready_q;
  logic [31:0] rdata_q;

  logic acc;
  logic wr_stat;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic start;
  logic done;
  logic mem_we;
  logic [ENTRY_W-1:0] mem_wdata;
  logic [ENTRY_W-1:0] mem_rdata;
  logic srch_hit;
  logic scan_hit;
  logic [NUM_PORTS-1:0] ent_ports;
  logic [NUM_PORTS-1:0] strip_left;
  logic [31:0] rd_val;

  // XOR fold of the MAC address into the bucket number
  function automatic logic [HASH_W-1:0] mac_hash(input logic [MAC_W-1:0] mac);
    logic [HASH_W-1:0] h;
    h = '0;
    for (int i = 0; i < MAC_W; i++)
    begin
      h[i % HASH_W] = h[i % HASH_W] ^ mac[i];
    end
    return h;
  endfunction

  // ==========================================================
  // Table memory
  table_mem #(
    .DEPTH(TABLE_DEPTH),
    .WIDTH(ENTRY_W)
  ) u_table (
    .sys_clk(sys_clk),
    .addr(cur_idx_q),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Bus decode
  always_comb
  begin
    acc = reg_req && !ready_q && !wait_q;
    wr_stat = 1'b0;
    wr_ctrl = 1'b0;
    wr_low = 1'b0;
    wr_high = 1'b0;
    rd_val = 32'h0000_0000;
    if (reg_addr == OFF_LOOKUP_STATUS)
    begin
      wr_stat = acc && reg_wr;
      rd_val = {event_q, 1'b0, ovf_q, age_index};
    end
    else if (reg_addr == OFF_TABLE_ACCESS_CTRL)
    begin
      wr_ctrl = acc && reg_wr;
      rd_val = {busy_q, cmd_q, 9'h000, addr_field_q};
    end
    else if (reg_addr == OFF_ENTRY_DATA_LOW)
    begin
      wr_low = acc && reg_wr;
      rd_val = data_low_q;
    end
    else if (reg_addr == OFF_ENTRY_DATA_HIGH)
    begin
      wr_high = acc && reg_wr;
      rd_val = {6'h00, data_high_q};
    end
    start = wr_ctrl && !busy_q && ((reg_wdata & CTRL_CMD_MASK) != 32'h0000_0000);
  end

  // ==========================================================
  // Entry evaluation and memory writes
  always_comb
  begin
    ent_ports = mem_rdata[ENT_PORT_LSB +: NUM_PORTS];
    strip_left = ent_ports & ~addr_field_q[NUM_PORTS-1:0];
    srch_hit = mem_rdata[ENT_VALID_BIT]
      && (mem_rdata[MAC_W-1:0] == {data_high_q[15:0], data_low_q});
    if (cmd_q[CTRL_STRIP_BIT])
    begin
      scan_hit = mem_rdata[ENT_VALID_BIT] && !mem_rdata[ENT_STATIC_BIT]
        && ((ent_ports & addr_field_q[NUM_PORTS-1:0]) != '0);
    end
    else
    begin
      scan_hit = mem_rdata[ENT_VALID_BIT] && (mem_rdata[ENT_STATIC_BIT]
        ? cmd_q[CTRL_PSTATIC_BIT] : cmd_q[CTRL_PLEARN_BIT]);
    end
    mem_we = 1'b0;
    mem_wdata = '0;
    done = 1'b0;
    case (state_q)
      ST_READ_CAP: done = 1'b1;
      ST_FETCH: done = 1'b1;
      ST_WRITE:
      begin
        mem_we = 1'b1;
        mem_wdata = {6'h00, data_high_q, data_low_q};
        done = 1'b1;
      end
      ST_CLEAR, ST_SRCH_DEL:
      begin
        mem_we = 1'b1;
        done = 1'b1;
      end
      ST_SRCH_CHK:
      begin
        done = (srch_hit && !cmd_q[CTRL_CLEAR_BIT])
          || (!srch_hit && cur_idx_q[BUCKET_W-1:0] == LAST_SLOT);
      end
      ST_SCAN_CHK:
      begin
        mem_we = scan_hit;
        if (cmd_q[CTRL_STRIP_BIT])
        begin
          mem_wdata = mem_rdata;
          mem_wdata[ENT_PORT_LSB +: NUM_PORTS] = strip_left;
          mem_wdata[ENT_VALID_BIT] = (strip_left != '0);
        end
        done = (cur_idx_q == LAST_IDX);
      end
      default:
      begin
        done = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Command engine and control register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      cmd_q <= '0;
      addr_field_q <= ADDR_RESET;
      cur_idx_q <= '0;
      free_found_q <= 1'b0;
      free_idx_q <= '0;
    end
    else if (done)
    begin
      busy_q <= 1'b0;
      cmd_q <= '0;
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            busy_q <= 1'b1;
            cmd_q <= reg_wdata[CTRL_STRIP_BIT:CTRL_PLEARN_BIT];
            addr_field_q <= reg_wdata[CTRL_ADDR_W-1:0];
            if (reg_wdata[CTRL_STRIP_BIT] || reg_wdata[CTRL_PSTATIC_BIT]
                || reg_wdata[CTRL_PLEARN_BIT])
            begin
              cur_idx_q <= '0;
              state_q <= ST_SCAN_RD;
            end
            else if (reg_wdata[CTRL_SEARCH_BIT])
            begin
              cur_idx_q <= {mac_hash({data_high_q[15:0], data_low_q}), {BUCKET_W{1'b0}}};
              free_found_q <= 1'b0;
              state_q <= ST_SRCH_RD;
            end
            else if (reg_wdata[CTRL_CLEAR_BIT])
            begin
              cur_idx_q <= reg_wdata[IDX_W-1:0];
              state_q <= ST_CLEAR;
            end
            else if (reg_wdata[CTRL_READ_BIT])
            begin
              cur_idx_q <= reg_wdata[IDX_W-1:0];
              state_q <= ST_READ_RD;
            end
            else if (reg_wdata[CTRL_WRITE_BIT])
            begin
              cur_idx_q <= reg_wdata[IDX_W-1:0];
              state_q <= ST_WRITE;
            end
            else
            begin
              state_q <= ST_FETCH;
            end
          end
          else if (wr_ctrl && !busy_q)
          begin
            addr_field_q <= reg_wdata[CTRL_ADDR_W-1:0];
          end
        end
        ST_READ_RD: state_q <= ST_READ_CAP;
        ST_SRCH_RD: state_q <= ST_SRCH_CHK;
        ST_SRCH_CHK:
        begin
          if (srch_hit)
          begin
            addr_field_q <= CTRL_ADDR_W'(cur_idx_q);
            state_q <= ST_SRCH_DEL;
          end
          else
          begin
            if (!mem_rdata[ENT_VALID_BIT] && !free_found_q)
            begin
              free_found_q <= 1'b1;
              free_idx_q <= cur_idx_q;
            end
            cur_idx_q <= cur_idx_q + 1'b1;
            state_q <= ST_SRCH_RD;
          end
        end
        ST_SCAN_RD: state_q <= ST_SCAN_CHK;
        ST_SCAN_CHK:
        begin
          cur_idx_q <= cur_idx_q + 1'b1;
          state_q <= ST_SCAN_RD;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
    // Search result: hit index, else first empty slot or last slot if full
    if (!rst && state_q == ST_SRCH_CHK && done)
    begin
      if (srch_hit)
      begin
        addr_field_q <= CTRL_ADDR_W'(cur_idx_q);
      end
      else if (free_found_q)
      begin
        addr_field_q <= CTRL_ADDR_W'(free_idx_q);
      end
      else
      begin
        addr_field_q <= CTRL_ADDR_W'(cur_idx_q);
      end
    end
  end

  // ==========================================================
  // Data holding registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      data_low_q <= 32'h0000_0000;
      data_high_q <= '0;
    end
    else if (state_q == ST_READ_CAP)
    begin
      data_low_q <= mem_rdata[31:0];
      data_high_q <= mem_rdata[57:32];
    end
    else if (state_q == ST_CLEAR || state_q == ST_SRCH_DEL)
    begin
      data_low_q <= 32'h0000_0000;
      data_high_q <= '0;
    end
    else if (state_q == ST_SRCH_CHK && srch_hit)
    begin
      data_high_q[25:16] <= mem_rdata[57:48];
    end
    else if (state_q == ST_SRCH_CHK && done)
    begin
      data_high_q[HIGH_VALID_BIT] <= 1'b0;
    end
    else if (state_q == ST_FETCH)
    begin
      data_low_q <= cap_mac_q[31:0];
      data_high_q <= '0;
      data_high_q[15:0] <= cap_mac_q[47:32];
      data_high_q[HIGH_VALID_BIT] <= cap_new_q;
      data_high_q[ENT_PORT_LSB - 32 + 32'(cap_port_q)] <= 1'b1;
    end
    else
    begin
      if (wr_low)
      begin
        data_low_q <= reg_wdata;
      end
      if (wr_high)
      begin
        data_high_q <= reg_wdata[DATA_HIGH_W-1:0];
      end
    end
  end

  // ==========================================================
  // Status: new-source flag and overflow counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      event_q <= 1'b0;
    end
    else if (src_miss)
    begin
      event_q <= 1'b1;
    end
    else if ((wr_stat && reg_wdata[STAT_EVENT_BIT]) || state_q == ST_FETCH)
    begin
      event_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ovf_q <= OVF_RESET;
    end
    else if (wr_stat && reg_wdata[STAT_OVF_CLR_BIT])
    begin
      ovf_q <= table_overflow ? 14'h0001 : OVF_RESET;
    end
    else if (table_overflow)
    begin
      ovf_q <= ovf_q + 1'b1;
    end
  end

  // ==========================================================
  // Unknown source capture
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cap_mac_q <= '0;
      cap_port_q <= '0;
      cap_new_q <= 1'b0;
    end
    else if (src_miss)
    begin
      cap_mac_q <= src_miss_mac;
      cap_port_q <= src_miss_port;
      cap_new_q <= 1'b1;
    end
    else if (state_q == ST_FETCH)
    begin
      cap_new_q <= 1'b0;
    end
  end

  // ==========================================================
  // Bus answer and stall
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wait_q <= 1'b0;
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ready_q <= 1'b0;
      if (acc)
      begin
        rdata_q <= reg_wr ? 32'h0000_0000 : rd_val;
        if (start && reg_wdata[CTRL_WAIT_BIT])
        begin
          wait_q <= 1'b1;
        end
        else
        begin
          ready_q <= 1'b1;
        end
      end
      else if (wait_q && done)
      begin
        wait_q <= 1'b0;
        ready_q <= 1'b1;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ready = ready_q;

endmodule

`default_nettype wire

// ===== pkg/mac_table_pkg.sv
/*
  Constants and types for the MAC table access controller: register byte
  addresses, field positions, reset values, entry layout and engine states.
  Assumes a processor bus that presents full 32-bit byte addresses.
*/
`default_nettype none

package mac_table_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] OFF_LOOKUP_STATUS = 32'h4405_0404;
  localparam logic [31:0] OFF_TABLE_ACCESS_CTRL = 32'h4405_0408;
  localparam logic [31:0] OFF_ENTRY_DATA_LOW = 32'h4405_040C;
  localparam logic [31:0] OFF_ENTRY_DATA_HIGH = 32'h4405_0410;

  // ==========================================================
  // lookup_status fields
  localparam int STAT_EVENT_BIT = 31;
  localparam int STAT_OVF_LSB = 16;
  localparam int STAT_OVF_W = 14;
  localparam int STAT_OVF_CLR_BIT = 16;
  localparam int STAT_AGE_W = 16;
  localparam logic [13:0] OVF_RESET = 14'h0000;

  // ==========================================================
  // table_access_ctrl fields
  localparam int CTRL_BUSY_BIT = 31;
  localparam int CTRL_STRIP_BIT = 30;
  localparam int CTRL_CLEAR_BIT = 29;
  localparam int CTRL_SEARCH_BIT = 28;
  localparam int CTRL_WAIT_BIT = 27;
  localparam int CTRL_READ_BIT = 26;
  localparam int CTRL_WRITE_BIT = 25;
  localparam int CTRL_FETCH_BIT = 24;
  localparam int CTRL_PSTATIC_BIT = 23;
  localparam int CTRL_PLEARN_BIT = 22;
  localparam int CTRL_ADDR_W = 13;
  localparam logic [31:0] CTRL_CMD_MASK = 32'h77C0_0000;
  localparam logic [12:0] ADDR_RESET = 13'h0000;

  // ==========================================================
  // Entry layout (64-bit word)
  localparam int ENTRY_W = 64;
  localparam int DATA_HIGH_W = 26;
  localparam int MAC_W = 48;
  localparam int ENT_VALID_BIT = 48;
  localparam int ENT_STATIC_BIT = 49;
  localparam int ENT_PORT_LSB = 50;
  localparam int ENT_PORT_MAX = 8;
  localparam int HIGH_VALID_BIT = 16;
  localparam int BUCKET_W = 3;
  localparam int TABLE_DEPTH_MAX = 8192;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_READ_RD,
    ST_READ_CAP,
    ST_WRITE,
    ST_CLEAR,
    ST_FETCH,
    ST_SRCH_RD,
    ST_SRCH_CHK,
    ST_SRCH_DEL,
    ST_SCAN_RD,
    ST_SCAN_CHK
  } engine_state_t;

endpackage

`default_nettype wire

// ===== rtl/table_mem.sv
/*
  Single-port table memory with registered read data.
  Assumes the owner presents one address per cycle; read data belongs to
  the address of the previous cycle. Contents are undefined after power-up.
*/
`timescale 1ns/10ps
`default_nettype none

module table_mem
#(
  parameter int DEPTH = 8192,
  parameter int WIDTH = 64
)
(
  input wire logic sys_clk,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic we,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Storage
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// ===== tb/mac_table_sva.sv
/*
  Port-level assertions for the MAC table access controller.
  Assumes binding to mac_table_access_control; sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module mac_table_sva
  import mac_table_pkg::*;
#(
  parameter int TABLE_DEPTH = 8192,
  parameter int NUM_PORTS = 5
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ready,
  input wire logic src_miss,
  input wire logic [MAC_W-1:0] src_miss_mac,
  input wire logic [$clog2(NUM_PORTS)-1:0] src_miss_port,
  input wire logic table_overflow,
  input wire logic [STAT_AGE_W-1:0] age_index
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Helpers
  wire logic rd_take = reg_req && !reg_wr && !reg_ready;
  wire logic ctrl_rd = reg_ready && !reg_wr && reg_addr == OFF_TABLE_ACCESS_CTRL;
  wire logic wait_cmd = reg_req && reg_wr && reg_addr == OFF_TABLE_ACCESS_CTRL &&
    reg_wdata[CTRL_WAIT_BIT] && (reg_wdata & CTRL_CMD_MASK) != 32'h0000_0000;

  // ==========================================================
  // Assertions
  a_read_answer: assert property (rd_take |=> reg_ready)
    else $error("read not answered next cycle");
  a_ready_single: assert property (reg_ready |=> !reg_ready)
    else $error("ready longer than one cycle");
  a_age_live: assert property (rd_take && reg_addr == OFF_LOOKUP_STATUS
    |=> reg_rdata[15:0] == $past(age_index)) else $error("aging index not shown");
  a_event_seen: assert property (rd_take && reg_addr == OFF_LOOKUP_STATUS
    && $past(src_miss) && !$past(rst) |=> reg_rdata[STAT_EVENT_BIT])
    else $error("miss did not set event flag");
  a_busy_has_cmd: assert property (ctrl_rd
    |-> reg_rdata[CTRL_BUSY_BIT] == ((reg_rdata & CTRL_CMD_MASK) != 32'h0000_0000))
    else $error("busy and command bits disagree");
  a_ctrl_reserved: assert property (ctrl_rd |-> reg_rdata[21:13] == 9'h000)
    else $error("control reserved bits not zero");
  a_high_reserved: assert property (reg_ready && !reg_wr
    && reg_addr == OFF_ENTRY_DATA_HIGH |-> reg_rdata[31:26] == 6'h00)
    else $error("high data reserved bits not zero");
  a_wait_stall: assert property (wait_cmd && !reg_ready
    && ($past(reg_ready) || !$past(reg_req)) |=> !reg_ready ##[1:400] reg_ready)
    else $error("waited command not stalled or never answered");

  // ==========================================================
  // Coverage
  c_scan_busy: cover property (ctrl_rd && reg_rdata[CTRL_STRIP_BIT]);
  c_miss: cover property (src_miss);
  c_overflow: cover property (table_overflow);
endmodule

bind mac_table_access_control mac_table_sva #(
  .TABLE_DEPTH(TABLE_DEPTH),
  .NUM_PORTS(NUM_PORTS)
) mac_table_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_ready(reg_ready), .src_miss(src_miss), .src_miss_mac(src_miss_mac),
  .src_miss_port(src_miss_port), .table_overflow(table_overflow), .age_index(age_index)
);

`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the MAC table access controller.
  Assumes the held-request register port and a 64-entry table.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import mac_table_pkg::*;
  localparam int DEPTH = 64;
  localparam logic [31:0] AS = OFF_LOOKUP_STATUS;
  localparam logic [31:0] AC = OFF_TABLE_ACCESS_CTRL;
  localparam logic [31:0] AL = OFF_ENTRY_DATA_LOW;
  localparam logic [31:0] AH = OFF_ENTRY_DATA_HIGH;
  localparam logic [31:0] WT = 32'h1 << CTRL_WAIT_BIT;
  localparam logic [31:0] CR = 32'h1 << CTRL_READ_BIT;
  localparam logic [31:0] CW = 32'h1 << CTRL_WRITE_BIT;
  localparam logic [31:0] CC = 32'h1 << CTRL_CLEAR_BIT;
  localparam logic [31:0] CS = 32'h1 << CTRL_SEARCH_BIT;
  localparam logic [31:0] CF = 32'h1 << CTRL_FETCH_BIT;
  localparam logic [47:0] M1 = 48'h6655_4433_2211;
  localparam logic [15:0] AGE = 16'hA5C3;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_ready;
  logic src_miss = 1'b0;
  logic [47:0] src_miss_mac = 48'h0000_0000_0000;
  logic [2:0] src_miss_port = 3'h0;
  logic table_overflow = 1'b0;
  logic [15:0] age_index = AGE;
  logic [31:0] q, lo, hi;
  int n_mismatch = 0;
  int checks = 0;
  int n, b1;

  always #20 sys_clk = ~sys_clk;

  mac_table_access_control #(.TABLE_DEPTH(DEPTH), .NUM_PORTS(5)) mac_table_access_control_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ready(reg_ready),
    .src_miss(src_miss), .src_miss_mac(src_miss_mac), .src_miss_port(src_miss_port),
    .table_overflow(table_overflow), .age_index(age_index)
  );

  // ==========================================================
  // Tasks
  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until ready is sampled high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge sys_clk);
    reg_req <= 1'b1;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (reg_ready !== 1'b1 && k < 400);
    r = reg_rdata;
    reg_req <= 1'b0;
    if (k >= 400)
    begin
      n_mismatch++;
      $display("Error at %0t: bus access hung", $time);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task automatic put(input int i, input logic [31:0] l, input logic [31:0] h);
    wr(AL, l);
    wr(AH, h);
    wr(AC, CW | WT | 32'(i));
  endtask

  task automatic get(input int i);
    wr(AC, CR | WT | 32'(i));
    bus(1'b0, AL, 32'h0000_0000, lo);
    bus(1'b0, AH, 32'h0000_0000, hi);
  endtask

  task automatic miss(input logic [47:0] m, input logic [2:0] p);
    @(posedge sys_clk);
    src_miss <= 1'b1;
    src_miss_mac <= m;
    src_miss_port <= p;
    @(posedge sys_clk);
    src_miss <= 1'b0;
  endtask

  function automatic logic [31:0] hi_of(input logic s, input logic v, input logic [4:0] p,
                                        input logic [15:0] m);
    return {9'h000, p, s, v, m};
  endfunction

  function automatic logic [2:0] fold(input logic [47:0] m);
    logic [2:0] h;
    h = 3'h0;
    for (int i = 0; i < 48; i++)
      h[i % 3] ^= m[i];
    return h;
  endfunction

  // ==========================================================
  // Tests
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(AS, {16'h0000, AGE});
    rd(AC, 32'h0000_0000);
    wr(AS, 32'h0000_FFFF);
    rd(AS, {16'h0000, AGE});
    for (int i = 0; i < DEPTH; i++)
      put(i, 32'h0000_0000, 32'h0000_0000);
    put(5, M1[31:0], hi_of(1'b0, 1'b1, 5'h06, M1[47:32]));
    wr(AL, 32'h0000_0000);
    wr(AH, 32'h0000_0000);
    get(5);
    chk(lo, M1[31:0]);
    chk(hi, hi_of(1'b0, 1'b1, 5'h06, M1[47:32]));
    rd(AL, M1[31:0]);
    put(6, 32'h1111_1111, hi_of(1'b0, 1'b1, 5'h01, 16'h2222));
    wr(AC, CC | WT | 32'd6);
    rd(AL, 32'h0000_0000);
    rd(AH, 32'h0000_0000);
    get(6);
    chk(lo | hi, 32'h0000_0000);
    b1 = 8 * int'(fold(M1));
    put(b1 + 2, M1[31:0], hi_of(1'b0, 1'b1, 5'h06, M1[47:32]));
    wr(AL, M1[31:0]);
    wr(AH, {16'h0000, M1[47:32]});
    wr(AC, CS | WT);
    rd(AH, hi_of(1'b0, 1'b1, 5'h06, M1[47:32]));
    rd(AC, 32'(b1 + 2));
    wr(AL, 32'h0000_0001);
    wr(AH, 32'h0000_0000);
    wr(AC, CS | WT);
    rd(AC, 32'd8);
    bus(1'b0, AH, 32'h0000_0000, q);
    chk(q & 32'h0001_0000, 32'h0000_0000);
    wr(AL, M1[31:0]);
    wr(AH, {16'h0000, M1[47:32]});
    wr(AC, CC | CS | WT);
    rd(AC, 32'(b1 + 2));
    rd(AL, 32'h0000_0000);
    get(b1 + 2);
    chk(lo | hi, 32'h0000_0000);
    miss(48'hBBAA_9988_7766, 3'd3);
    // Status read taken the edge after a miss pulse
    fork
      miss(48'h0C0B_0A09_0807, 3'd1);
      begin
        @(posedge sys_clk);
        rd(AS, {16'h8000, AGE});
      end
    join
    wr(AC, CF | WT);
    rd(AL, 32'h0A09_0807);
    rd(AH, hi_of(1'b0, 1'b1, 5'h02, 16'h0C0B));
    rd(AS, {16'h0000, AGE});
    wr(AC, CF | WT);
    bus(1'b0, AH, 32'h0000_0000, q);
    chk(q & 32'h0001_0000, 32'h0000_0000);
    miss(48'h0000_0000_0042, 3'd0);
    wr(AS, 32'h8000_0000);
    rd(AS, {16'h0000, AGE});
    repeat (3)
    begin
      @(posedge sys_clk);
      table_overflow <= 1'b1;
      @(posedge sys_clk);
      table_overflow <= 1'b0;
    end
    rd(AS, {16'h0003, AGE});
    wr(AS, 32'h0000_0000);
    rd(AS, {16'h0003, AGE});
    wr(AS, 32'h0001_0000);
    rd(AS, {16'h0000, AGE});
    age_index <= 16'h5A3C;
    rd(AS, 32'h0000_5A3C);
    put(1, 32'h0000_00A1, hi_of(1'b1, 1'b1, 5'h03, 16'h0000));
    put(2, 32'h0000_00B2, hi_of(1'b0, 1'b1, 5'h03, 16'h0000));
    put(3, 32'h0000_00C3, hi_of(1'b0, 1'b1, 5'h01, 16'h0000));
    put(4, 32'h0000_00D4, hi_of(1'b0, 1'b0, 5'h01, 16'h0000));
    wr(AC, (32'h1 << CTRL_STRIP_BIT) | 32'h0000_0001);
    rd(AC, 32'hC000_0001);
    q = 32'hFFFF_FFFF;
    n = 0;
    // No new command until the scan ends
    while (q[31] !== 1'b0 && n < 200)
    begin
      bus(1'b0, AC, 32'h0000_0000, q);
      n++;
    end
    chk(q & 32'hFFC0_0000, 32'h0000_0000);
    get(1);
    chk(hi, hi_of(1'b1, 1'b1, 5'h03, 16'h0000));
    get(2);
    chk(hi, hi_of(1'b0, 1'b1, 5'h02, 16'h0000));
    get(3);
    chk(hi, 32'h0000_0000);
    get(4);
    chk(hi, hi_of(1'b0, 1'b0, 5'h01, 16'h0000));
    get(5);
    chk(hi, hi_of(1'b0, 1'b1, 5'h06, M1[47:32]));
    wr(AC, (32'h1 << CTRL_PLEARN_BIT) | WT);
    get(2);
    chk(lo, 32'h0000_0000);
    get(1);
    chk(lo, 32'h0000_00A1);
    get(4);
    chk(lo, 32'h0000_00D4);
    wr(AC, (32'h1 << CTRL_PSTATIC_BIT) | WT);
    get(1);
    chk(lo | hi, 32'h0000_0000);
    finish_test;
  end

  // ==========================================================
  // Watchdog
  initial
  begin
    #(40 * 30000);
    n_mismatch++;
    finish_test;
  end
endmodule

`default_nettype wire
